// ### core/ccc_charge_cycle_controller.sv
// charge cycle controller: cycle state, safety timer, status pins, protections
`timescale 1ns/1ps
`include "ccc_params.svh"

module ccc_charge_cycle_controller (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_charge_en_n,
	input wire ccc_pkg::ccc_chg_sense_t i_chg,
	input wire ccc_pkg::ccc_input_sense_t i_in,
	input wire ccc_pkg::ccc_boost_sense_t i_bst,
	output ccc_pkg::ccc_ctrl_t o_ctrl,
	output logic o_safety_fault,
	output logic o_boost_disabled,
	output logic o_power_good_n_o,
	output logic o_power_good_n_oe,
	output logic o_stat_o,
	output logic o_stat_oe
);

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CHARGE,
		ST_SUSPEND,
		ST_DONE
	} ccc_state_t;

	ccc_state_t state_r;
	ccc_state_t state_nxt;
	logic [`CCC_TICK_W-1:0] tick_cnt_r;
	logic tick;
	logic half_r;
	logic blink_r;
	logic [`CCC_SAFE_W-1:0] safe_cnt_r;
	logic safe_fault_r;
	logic ce_n_d_r;
	logic [2:0] retry_r;
	logic bst_dis_r;
	logic short_d_r;
	logic tshut_r;
	ccc_pkg::ccc_ctrl_t ctrl_r;

	// --------------------------------------------------------------
	// decode
	// --------------------------------------------------------------
	function automatic logic zone_is(input ccc_pkg::ccc_zone_t z, input ccc_pkg::ccc_zone_t w);
		zone_is = (z == w);
	endfunction

	wire in_ov = i_in.input_overvoltage | i_in.system_overvoltage;
	wire cool = zone_is(i_chg.zone, ccc_pkg::CCC_ZONE_COOL);
	wire warm = zone_is(i_chg.zone, ccc_pkg::CCC_ZONE_WARM);
	wire ts_fault = i_chg.temp_out_of_range;
	wire enabled = ~i_charge_en_n;
	wire ce_rise = i_charge_en_n & ~ce_n_d_r;
	wire can_start = i_chg.converter_on & enabled & ~ts_fault & ~safe_fault_r;
	wire term_ok = i_chg.charge_i_low & i_chg.vbat_above_rech
		& ~i_chg.input_power_limiting & ~i_chg.thermal_reg
		& ~cool & ~warm;
	wire fault = ts_fault | in_ov | safe_fault_r;
	wire half_rate = i_chg.input_power_limiting | i_chg.thermal_reg | cool;
	wire [`CCC_SAFE_W-1:0] safe_lim = i_chg.vbat_above_lowbat
		? `CCC_SAFE_W'(`CCC_LONG_LIMIT) : `CCC_SAFE_W'(`CCC_SHORT_LIMIT);
	wire safe_step = tick & (state_r == ST_CHARGE) & ~fault & (~half_rate | half_r);
	wire restart = (state_r != ST_CHARGE) & (state_nxt == ST_CHARGE)
		& (state_r != ST_SUSPEND);
	wire short_rise = i_bst.boost_short & ~short_d_r;
	wire boost_run = i_bst.boost_req & i_bst.boost_ts_ok & ~bst_dis_r & ~tshut_r
		& ~i_bst.boost_short;
	wire pg_ok = i_in.above_uvlo & i_in.above_bat & ~i_in.input_overvoltage
		& ~i_in.poor_source & i_in.detect_done;
	wire tick_end = (tick_cnt_r == `CCC_TICK_W'(`CCC_TICK_CYC - 1));
	assign tick = tick_end;

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (can_start) begin
					state_nxt = ST_CHARGE;
				end
			end
			ST_CHARGE: begin
				if (!enabled) begin
					state_nxt = ST_IDLE;
				end else if (fault) begin
					state_nxt = ST_SUSPEND;
				end else if (term_ok) begin
					state_nxt = ST_DONE;
				end
			end
			ST_SUSPEND: begin
				if (!enabled) begin
					state_nxt = ST_IDLE;
				end else if (!fault && i_chg.converter_on) begin
					state_nxt = ST_CHARGE;
				end
			end
			ST_DONE: begin
				if (!enabled) begin
					state_nxt = ST_IDLE;
				end else if (!i_chg.vbat_above_rech && can_start) begin
					state_nxt = ST_CHARGE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// --------------------------------------------------------------
	// outputs to the power stage
	// --------------------------------------------------------------
	ccc_pkg::ccc_ctrl_t ctrl_nxt;
	always_comb begin
		ctrl_nxt = '0;
		ctrl_nxt.buck_switch_en = i_chg.converter_on & ~in_ov & ~i_bst.boost_req;
		ctrl_nxt.boost_switch_en = boost_run & ~i_bst.boost_overvoltage_limit;
		ctrl_nxt.charging = (state_r == ST_CHARGE);
		ctrl_nxt.battery_switch = ((state_r == ST_CHARGE) | (state_r == ST_SUSPEND)
			| i_bst.boost_req) & ~tshut_r;
		ctrl_nxt.warm_voltage = warm;
		ctrl_nxt.current_pct = cool ? `CCC_COOL_PCT : `CCC_FULL_PCT;
	end

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			state_r <= ST_IDLE;
			ce_n_d_r <= 1'b1;
			ctrl_r <= '0;
		end else begin
			state_r <= (ce_rise && state_r == ST_DONE) ? ST_IDLE : state_nxt;
			ce_n_d_r <= i_charge_en_n;
			ctrl_r <= ctrl_nxt;
		end
	end

	// slow timebase and blink
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			tick_cnt_r <= '0;
			half_r <= 1'b0;
			blink_r <= 1'b0;
		end else begin
			tick_cnt_r <= tick_end ? '0 : tick_cnt_r + `CCC_TICK_W'(1);
			if (tick) begin
				half_r <= ~half_r;
				blink_r <= ~blink_r;
			end
		end
	end

	// safety timer
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			safe_cnt_r <= '0;
			safe_fault_r <= 1'b0;
		end else if (restart || (state_nxt == ST_IDLE && state_r != ST_IDLE)) begin
			safe_cnt_r <= '0;
			safe_fault_r <= 1'b0;
		end else if (safe_step) begin
			if (safe_cnt_r + `CCC_SAFE_W'(2) >= safe_lim) begin
				safe_fault_r <= 1'b1;
			end else begin
				safe_cnt_r <= safe_cnt_r + `CCC_SAFE_W'(2);
			end
		end
	end

	// boost short retries and thermal shutdown
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			retry_r <= '0;
			bst_dis_r <= 1'b0;
			short_d_r <= 1'b0;
			tshut_r <= 1'b0;
		end else begin
			short_d_r <= i_bst.boost_short;
			if (!i_bst.boost_req) begin
				retry_r <= '0;
				bst_dis_r <= 1'b0;
			end else if (short_rise && !bst_dis_r) begin
				if (retry_r == `CCC_RETRY_MAX) begin
					bst_dis_r <= 1'b1;
				end else begin
					retry_r <= retry_r + 3'h1;
				end
			end
			if (i_bst.boost_req && i_bst.tj_above_shut) begin
				tshut_r <= 1'b1;
			end else if (i_bst.tj_below_hys) begin
				tshut_r <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// status pins, open drain: oe low drives low
	// --------------------------------------------------------------
	logic pg_oe_r;
	logic stat_oe_r;
	wire stat_low = (state_r == ST_CHARGE) & ~i_bst.boost_req;
	wire stat_blink = (state_r == ST_SUSPEND) | (safe_fault_r & enabled);
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			pg_oe_r <= 1'b1;
			stat_oe_r <= 1'b1;
		end else begin
			pg_oe_r <= ~pg_ok;
			stat_oe_r <= ~(stat_low | (stat_blink & blink_r));
		end
	end

	assign o_ctrl = ctrl_r;
	assign o_safety_fault = safe_fault_r;
	assign o_boost_disabled = bst_dis_r;
	assign o_power_good_n_o = 1'b0;
	assign o_power_good_n_oe = pg_oe_r;
	assign o_stat_o = 1'b0;
	assign o_stat_oe = stat_oe_r;

endmodule

// ### pkg/ccc_params.svh
// timing counts and field constants for the charge cycle controller
`ifndef CCC_PARAMS_SVH
`define CCC_PARAMS_SVH

// --------------------------------------------------------------
// slow timebase
// --------------------------------------------------------------
`define CCC_CLK_HZ 100000000
`define CCC_TICK_HZ 2
`define CCC_TICK_CYC (`CCC_CLK_HZ / `CCC_TICK_HZ)
`define CCC_TICK_W 26

// --------------------------------------------------------------
// safety timer, in half-second ticks, doubled for half-rate counting
// --------------------------------------------------------------
`define CCC_SHORT_HOURS 2
`define CCC_LONG_HOURS 10
`define CCC_SHORT_LIMIT (`CCC_SHORT_HOURS * 3600 * `CCC_TICK_HZ * 2)
`define CCC_LONG_LIMIT (`CCC_LONG_HOURS * 3600 * `CCC_TICK_HZ * 2)
`define CCC_SAFE_W 18

// --------------------------------------------------------------
// current scaling, percent of fast charge current
// --------------------------------------------------------------
`define CCC_TERM_PCT 7'h05
`define CCC_COOL_PCT 7'h14
`define CCC_FULL_PCT 7'h64

// --------------------------------------------------------------
// boost short retries
// --------------------------------------------------------------
`define CCC_RETRY_MAX 3'h7

`endif

// ### pkg/ccc_pkg.sv
// types for the charge cycle controller
package ccc_pkg;

	typedef enum logic [1:0] {
		CCC_ZONE_COLD,
		CCC_ZONE_COOL,
		CCC_ZONE_NORMAL,
		CCC_ZONE_WARM
	} ccc_zone_t;

	typedef struct packed {
		logic converter_on;
		logic charge_i_low;
		logic vbat_above_rech;
		logic vbat_above_lowbat;
		logic input_power_limiting;
		logic thermal_reg;
		logic temp_out_of_range;
		ccc_zone_t zone;
	} ccc_chg_sense_t;

	typedef struct packed {
		logic above_uvlo;
		logic above_bat;
		logic input_overvoltage;
		logic poor_source;
		logic detect_done;
		logic system_overvoltage;
	} ccc_input_sense_t;

	typedef struct packed {
		logic boost_req;
		logic boost_ts_ok;
		logic boost_short;
		logic boost_overvoltage_limit;
		logic tj_above_shut;
		logic tj_below_hys;
	} ccc_boost_sense_t;

	typedef struct packed {
		logic buck_switch_en;
		logic boost_switch_en;
		logic battery_switch;
		logic charging;
		logic warm_voltage;
		logic [6:0] current_pct;
	} ccc_ctrl_t;

endpackage

// ### testbench/ccc_assertions.sv
// checker on the charge cycle controller ports
`timescale 1ns/1ps
`include "ccc_params.svh"
module ccc_assertions (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_charge_en_n,
	input wire ccc_pkg::ccc_chg_sense_t i_chg,
	input wire ccc_pkg::ccc_input_sense_t i_in,
	input wire ccc_pkg::ccc_boost_sense_t i_bst,
	input wire ccc_pkg::ccc_ctrl_t o_ctrl,
	input wire logic o_safety_fault,
	input wire logic o_boost_disabled,
	input wire logic o_power_good_n_o,
	input wire logic o_power_good_n_oe,
	input wire logic o_stat_o,
	input wire logic o_stat_oe
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	logic in_ok;
	assign in_ok = i_in.above_uvlo & i_in.above_bat & !i_in.input_overvoltage
		& !i_in.poor_source & i_in.detect_done;
	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	power_good_a: assert property ($past(i_nrst) |-> o_power_good_n_oe == !$past(in_ok))
		else $error("power good pin wrong");
	ov_halt_a: assert property (i_in.input_overvoltage || i_in.system_overvoltage
		|=> !o_ctrl.buck_switch_en) else $error("switching during overvoltage");
	boost_ovp_a: assert property (i_bst.boost_overvoltage_limit
		|=> !o_ctrl.boost_switch_en) else $error("boost over limit");
	boost_temp_a: assert property (!i_bst.boost_ts_ok |=> !o_ctrl.boost_switch_en)
		else $error("boost outside window");
	boost_off_a: assert property (o_boost_disabled [*2] |-> !o_ctrl.boost_switch_en)
		else $error("boost after retries");
	boost_shut_a: assert property (i_bst.tj_above_shut [*2] |=> !o_ctrl.boost_switch_en)
		else $error("boost while hot");
	no_enable_a: assert property (i_charge_en_n [*2] |=> !o_ctrl.charging)
		else $error("charging while disabled");
	cool_limit_a: assert property (i_chg.zone == ccc_pkg::CCC_ZONE_COOL
		|=> !o_ctrl.charging || o_ctrl.current_pct == `CCC_COOL_PCT) else $error("cool current");
	warm_volt_a: assert property (i_chg.zone == ccc_pkg::CCC_ZONE_WARM
		|=> !o_ctrl.charging || o_ctrl.warm_voltage) else $error("warm voltage");
	stat_low_a: assert property (o_ctrl.charging && !$past(i_bst.boost_req) |-> !o_stat_oe)
		else $error("status not low");
	cover property (o_ctrl.charging ##1 !o_ctrl.charging);
	cover property ($rose(o_boost_disabled));
	cover property ($fell(o_power_good_n_oe));
endmodule
bind ccc_charge_cycle_controller ccc_assertions i_chk (.i_ref_clk, .i_nrst, .i_charge_en_n,
	.i_chg, .i_in, .i_bst, .o_ctrl, .o_safety_fault, .o_boost_disabled, .o_power_good_n_o,
	.o_power_good_n_oe, .o_stat_o, .o_stat_oe);

// ### testbench/ccc_battery_model.sv
// battery model that fills while charged and empties while drained
`timescale 1ns/1ps
module ccc_battery_model (
	input wire logic i_ref_clk,
	input wire logic i_charging,
	input wire logic i_drain,
	output logic o_low_i,
	output logic o_above_rech,
	output logic o_above_lowbat
);
	logic [3:0] level_r;
	initial level_r = 4'h0;
	always @(posedge i_ref_clk) begin
		if (i_drain && level_r != 4'h0) begin
			level_r <= level_r - 4'h1;
		end else if (i_charging && level_r != 4'hF) begin
			level_r <= level_r + 4'h1;
		end
	end
	assign o_low_i = level_r >= 4'hC;
	assign o_above_rech = level_r >= 4'hA;
	assign o_above_lowbat = level_r >= 4'h4;
endmodule

// ### testbench/ccc_charge_cycle_controller_tb.sv
// testbench for the charge cycle controller
`timescale 1ns/1ps
`include "ccc_params.svh"
module ccc_charge_cycle_controller_tb;
	logic clk, nrst, ce_n, drain, lim, treg, oor, b_low, b_rech, b_lowb;
	ccc_pkg::ccc_zone_t zone;
	ccc_pkg::ccc_chg_sense_t chg;
	ccc_pkg::ccc_input_sense_t in_s;
	ccc_pkg::ccc_boost_sense_t bst;
	ccc_pkg::ccc_ctrl_t o_ctrl;
	logic o_sf, o_bd, o_pg_o, o_pg_oe, o_st_o, o_st_oe;
	int miscompares = 0;
	int comparisons = 0;
	assign chg = {1'b1, b_low, b_rech, b_lowb, lim, treg, oor, zone};
	ccc_charge_cycle_controller i_dut (.i_ref_clk(clk), .i_nrst(nrst), .i_charge_en_n(ce_n),
		.i_chg(chg), .i_in(in_s), .i_bst(bst), .o_ctrl(o_ctrl), .o_safety_fault(o_sf),
		.o_boost_disabled(o_bd), .o_power_good_n_o(o_pg_o), .o_power_good_n_oe(o_pg_oe),
		.o_stat_o(o_st_o), .o_stat_oe(o_st_oe));
	ccc_battery_model i_bat (.i_ref_clk(clk), .i_charging(o_ctrl.charging), .i_drain(drain),
		.o_low_i(b_low), .o_above_rech(b_rech), .o_above_lowbat(b_lowb));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input logic [6:0] act, input logic [6:0] exp);
		#1;
		comparisons++;
		if (act !== exp) begin
			miscompares++;
			$display("ERROR %0t: got %h want %h", $time, act, exp);
		end
	endtask
	task automatic wait_chg(input logic e);
		for (int i = 0; i < 8 && o_ctrl.charging !== e; i++) @(posedge clk) #1;
		chk(o_ctrl.charging, {6'h0, e});
	endtask
	task automatic shorts(input int n);
		repeat (n) begin
			step(2);
			bst.boost_short <= 1'b1;
			step(2);
			bst.boost_short <= 1'b0;
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#20us;
		miscompares++;
		tally_and_finish();
	end
	initial begin
		// --------------------------------------------------------------
		// reset, idle with good input
		// --------------------------------------------------------------
		{nrst, drain, lim, treg, oor} = 5'h00;
		ce_n = 1'b1;
		zone = ccc_pkg::CCC_ZONE_NORMAL;
		in_s = 6'h32; // qualified input, detection done
		bst = 6'h00;
		step(4);
		nrst <= 1'b1;
		step(2);
		chk(o_pg_oe, 7'h0);
		chk(o_st_oe, 7'h1);
		chk(o_pg_o, 7'h0);
		chk(o_st_o, 7'h0);
		chk(o_sf, 7'h0);
		step(1);
		in_s.poor_source <= 1'b1;
		step(2);
		chk(o_pg_oe, 7'h1);
		$display("test power done");
		// --------------------------------------------------------------
		// start, zones, termination
		// --------------------------------------------------------------
		step(1);
		in_s.poor_source <= 1'b0;
		ce_n <= 1'b0;
		oor <= 1'b1;
		step(4);
		chk(o_ctrl.charging, 7'h0);
		step(1);
		oor <= 1'b0;
		wait_chg(1'b1);
		chk(o_st_oe, 7'h0);
		chk(o_ctrl.current_pct, `CCC_FULL_PCT);
		chk(o_ctrl.battery_switch, 7'h1);
		step(1);
		zone <= ccc_pkg::CCC_ZONE_COOL;
		step(12);
		chk(o_ctrl.current_pct, `CCC_COOL_PCT);
		chk(o_ctrl.charging, 7'h1);
		step(1);
		zone <= ccc_pkg::CCC_ZONE_WARM;
		step(6);
		chk(o_ctrl.warm_voltage, 7'h1);
		chk(o_ctrl.charging, 7'h1);
		step(1);
		zone <= ccc_pkg::CCC_ZONE_NORMAL;
		wait_chg(1'b0);
		chk(o_ctrl.battery_switch, 7'h0);
		chk(o_ctrl.buck_switch_en, 7'h1);
		chk(o_st_oe, 7'h1);
		$display("test charge done");
		// --------------------------------------------------------------
		// recharge, limiting, fault suspend, restart
		// --------------------------------------------------------------
		step(1);
		drain <= 1'b1;
		lim <= 1'b1;
		wait_chg(1'b1);
		step(1);
		drain <= 1'b0;
		step(8);
		chk(o_ctrl.charging, 7'h1);
		step(1);
		in_s.input_overvoltage <= 1'b1;
		step(2);
		chk(o_ctrl.buck_switch_en, 7'h0);
		wait_chg(1'b0);
		step(1);
		in_s.input_overvoltage <= 1'b0;
		wait_chg(1'b1);
		step(1);
		lim <= 1'b0;
		treg <= 1'b1;
		step(4);
		chk(o_ctrl.charging, 7'h1);
		step(1);
		treg <= 1'b0;
		wait_chg(1'b0);
		step(1);
		ce_n <= 1'b1;
		step(3);
		chk(o_st_oe, 7'h1);
		step(1);
		ce_n <= 1'b0;
		wait_chg(1'b1);
		$display("test recharge done");
		// --------------------------------------------------------------
		// boost short retries
		// --------------------------------------------------------------
		step(1);
		bst.boost_req <= 1'b1;
		bst.boost_ts_ok <= 1'b1;
		shorts(7);
		step(3);
		chk(o_bd, 7'h0);
		chk(o_ctrl.boost_switch_en, 7'h1);
		shorts(1);
		step(3);
		chk(o_bd, 7'h1);
		chk(o_ctrl.boost_switch_en, 7'h0);
		step(1);
		bst.boost_overvoltage_limit <= 1'b1;
		bst.tj_above_shut <= 1'b1;
		step(3);
		bst.boost_req <= 1'b0;
		step(3);
		chk(o_bd, 7'h0);
		$display("test boost done");
		tally_and_finish();
	end
endmodule
